// >>> rtl/flash_prog_core.sv
`timescale 1ns/100ps
`include "flash_prog_defs.svh"

// Contract
// - Security program: 42h, address, data bytes
// - Timed program cycle, busy flag, latch cleared
// - Locked security registers ignore program
// - Security address: 00h, select 1-3, 0000
// - Soft reset aborts work, clears volatile bits
// - Reset needs 66h directly before 99h
// - Other command after 66h cancels enable
// - About 30 us reset, commands refused
// - Single-lane page program frame layout
// - Data past page end wraps to start
// - Last 256 bytes win, others untouched
// - Execute only on whole-byte chip select
// - Protected pages are never programmed
// - Quad program only with quad enable
// - Quad program sends data on four lanes
module flash_prog_core
    import flash_prog_pkg::*;
#(
    parameter int PROG_CYCLES = `PAGE_PROGRAM_CYCLES,
    parameter int FIFO_DEPTH = 2
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic [3:0] i_io,
    input wire logic i_quad_enable,
    input wire logic [4:0] i_block_protect_bits,
    input wire logic [2:0] i_security_lock_bits,
    input wire logic i_write_enable_set,
    output logic o_write_enable_latch,
    output logic o_write_in_progress,
    output logic o_reset_busy,
    output logic o_soft_reset,
    output logic o_cmd_ignored,
    output logic o_rx_stall,
    output logic o_prog_we,
    output logic [23:0] o_prog_addr,
    output logic [7:0] o_prog_data,
    output logic o_prog_security
);
    localparam int RESET_CYCLES = `SOFT_RESET_CYCLES;

    generate
        if (PROG_CYCLES <= `PAGE_BYTES || PROG_CYCLES >= (1 << 24)) begin : g_bad_prog
            $error("PROG_CYCLES must exceed the page size and fit 24 bits");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Serial side and crossing
    // ------------------------------------------------------------------
    spi_rx_if rx_if ();

    spi_link_rx u_link (
        .i_rst_b(i_rst_b),
        .i_sck(i_sck),
        .i_cs_n(i_cs_n),
        .i_io(i_io),
        .i_quad_enable(i_quad_enable),
        .link(rx_if.link)
    );

    logic cs_sync1_q, cs_sync2_q, cs_prev_q;
    logic tgl_sync1_q, tgl_sync2_q, tgl_prev_q;
    logic part_sync1_q, part_sync2_q;
    logic byte_evt, cs_rise;

    // Two-stage synchronisers, edge detect after the second stage
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs_sync1_q <= 1'b1;
            cs_sync2_q <= 1'b1;
            cs_prev_q <= 1'b1;
            tgl_sync1_q <= 1'b0;
            tgl_sync2_q <= 1'b0;
            tgl_prev_q <= 1'b0;
            part_sync1_q <= 1'b0;
            part_sync2_q <= 1'b0;
        end else if (i_clk_en) begin
            cs_sync1_q <= i_cs_n;
            cs_sync2_q <= cs_sync1_q;
            cs_prev_q <= cs_sync2_q;
            tgl_sync1_q <= rx_if.byte_toggle;
            tgl_sync2_q <= tgl_sync1_q;
            tgl_prev_q <= tgl_sync2_q;
            part_sync1_q <= rx_if.partial;
            part_sync2_q <= part_sync1_q;
        end
    end

    assign byte_evt = tgl_sync2_q ^ tgl_prev_q;
    assign cs_rise = cs_sync2_q & ~cs_prev_q;

    // ------------------------------------------------------------------
    // Two-entry byte buffer
    // ------------------------------------------------------------------
    // The byte register stays stable for a whole byte time after the toggle
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
    byte_t fifo_out_data;
    logic end_pend_q, end_pend_d;

    byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_clk_en(i_clk_en),
        .i_in_valid(byte_evt),
        .o_in_ready(fifo_in_ready),
        .i_in_data(rx_if.rx_byte),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data)
    );

    assign fifo_out_ready = ~end_pend_q | fifo_out_valid;
    assign o_rx_stall = ~fifo_in_ready;

    // ------------------------------------------------------------------
    // Page buffer
    // ------------------------------------------------------------------
    byte_t page_mem [`PAGE_BYTES];
    logic mem_we;
    logic [7:0] mem_addr;

    always_ff @(posedge i_clock) begin
        if (i_clk_en && mem_we) begin
            page_mem[mem_addr] <= fifo_out_data;
        end
    end

    // Block protect decode: low nibble sizes the region, bit 4 picks bottom
    function automatic logic page_protected(input logic [4:0] bp, input logic [7:0] blk);
        logic [8:0] span;
        span = 9'h000;
        if (bp[3:0] >= 4'h9) begin
            span = 9'h100;
        end else if (bp[3:0] != 4'h0) begin
            span = 9'h001 << (bp[3:0] - 4'h1);
        end
        if (bp[4]) begin
            page_protected = ({1'b0, blk} < span);
        end else begin
            page_protected = ({1'b0, blk} >= (9'h100 - span));
        end
    endfunction : page_protected

    // ------------------------------------------------------------------
    // Command engine
    // ------------------------------------------------------------------
    engine_state_t state_q, state_d;
    logic [2:0] idx_q, idx_d;
    byte_t opcode_q, opcode_d;
    logic [23:0] addr_q, addr_d;
    logic [7:0] wr_ptr_q, wr_ptr_d;
    logic [`PAGE_BYTES-1:0] mask_q, mask_d;
    logic has_data_q, has_data_d;
    logic rst_en_q, rst_en_d;
    logic wel_q, wel_d, wip_q, wip_d;
    logic [23:0] timer_q, timer_d;
    logic [8:0] walk_q, walk_d;
    logic [15:0] page_q, page_d;
    logic sec_q, sec_d;
    logic we_q, we_d, soft_q, soft_d, ign_q, ign_d;
    logic [23:0] paddr_q, paddr_d;
    byte_t pdata_q, pdata_d;
    logic pop, frame_end, whole, sec_addr_ok, sec_locked, prog_ok;

    assign pop = fifo_out_valid & fifo_out_ready;
    assign frame_end = end_pend_q & ~fifo_out_valid;
    assign whole = ~part_sync2_q;
    assign sec_addr_ok = (addr_q[23:16] == `SEC_ADDR_HI) && (addr_q[11:8] == `SEC_ADDR_MID)
                         && (addr_q[15:12] >= `SEC_SEL_FIRST) && (addr_q[15:12] <= `SEC_SEL_LAST);
    assign sec_locked = i_security_lock_bits[2'(addr_q[13:12] - 2'h1)];

    // Program acceptance at a clean frame end
    always_comb begin
        prog_ok = 1'b0;
        if (whole && has_data_q && wel_q && state_q == ST_IDLE) begin
            unique case (opcode_q)
                `OP_PAGE_PROG: prog_ok = ~page_protected(i_block_protect_bits, addr_q[23:16]);
                `OP_QUAD_PROG: prog_ok = i_quad_enable
                                         & ~page_protected(i_block_protect_bits, addr_q[23:16]);
                `OP_SEC_PROG: prog_ok = sec_addr_ok & ~sec_locked;
                default: prog_ok = 1'b0;
            endcase
        end
    end

    // Next state of the engine
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        opcode_d = opcode_q;
        addr_d = addr_q;
        wr_ptr_d = wr_ptr_q;
        mask_d = mask_q;
        has_data_d = has_data_q;
        rst_en_d = rst_en_q;
        wel_d = wel_q;
        wip_d = wip_q;
        timer_d = timer_q;
        walk_d = walk_q;
        page_d = page_q;
        sec_d = sec_q;
        end_pend_d = end_pend_q | cs_rise;
        we_d = 1'b0;
        soft_d = 1'b0;
        ign_d = 1'b0;
        mem_we = 1'b0;
        mem_addr = wr_ptr_q;
        paddr_d = {page_q, walk_q[7:0]};
        pdata_d = page_mem[walk_q[7:0]];
        // Bytes of the frame: opcode, three address bytes, then data
        if (pop) begin
            if (idx_q == 3'h0) begin
                opcode_d = fifo_out_data;
                if (state_q == ST_IDLE) begin
                    mask_d = '0;
                end
            end else if (idx_q != `IDX_DATA) begin
                addr_d = {addr_q[15:0], fifo_out_data};
                if (idx_q == `IDX_LAST_ADDR) begin
                    wr_ptr_d = fifo_out_data;
                end
            end else if (state_q == ST_IDLE) begin
                mem_we = 1'b1;
                mask_d[wr_ptr_q] = 1'b1;
                wr_ptr_d = 8'(wr_ptr_q + 8'h01);
                has_data_d = 1'b1;
            end
            if (idx_q != `IDX_DATA) begin
                idx_d = 3'(idx_q + 3'h1);
            end
        end
        unique case (state_q)
            ST_IDLE: begin
            end
            ST_PROG: begin
                timer_d = 24'(timer_q - 24'h1);
                if (!walk_q[8]) begin
                    we_d = mask_q[walk_q[7:0]];
                    walk_d = 9'(walk_q + 9'h001);
                end
                if (timer_q == 24'h1) begin
                    wip_d = 1'b0;
                    state_d = ST_IDLE;
                end
            end
            ST_RESET: begin
                timer_d = 24'(timer_q - 24'h1);
                if (timer_q == 24'h1) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
        // Frame end once the buffer has drained
        if (frame_end) begin
            end_pend_d = 1'b0;
            idx_d = 3'h0;
            has_data_d = 1'b0;
            if (state_q != ST_RESET && idx_q != 3'h0) begin
                rst_en_d = 1'b0;
                if (whole && idx_q == 3'h1 && opcode_q == `OP_RESET_ENABLE) begin
                    rst_en_d = 1'b1;
                end else if (whole && idx_q == 3'h1 && opcode_q == `OP_RESET && rst_en_q) begin
                    state_d = ST_RESET;
                    timer_d = 24'(RESET_CYCLES);
                    wel_d = 1'b0;
                    wip_d = 1'b0;
                    we_d = 1'b0;
                    soft_d = 1'b1;
                end else if (prog_ok) begin
                    state_d = ST_PROG;
                    timer_d = 24'(PROG_CYCLES);
                    wip_d = 1'b1;
                    wel_d = 1'b0;
                    walk_d = 9'h000;
                    page_d = addr_q[23:8];
                    sec_d = (opcode_q == `OP_SEC_PROG);
                end else if (opcode_q == `OP_PAGE_PROG || opcode_q == `OP_QUAD_PROG
                             || opcode_q == `OP_SEC_PROG) begin
                    ign_d = 1'b1;
                end
            end
        end
        // Write enable from outside wins over the program-start clear, but not on entry to or during soft reset
        if (i_write_enable_set && state_d != ST_RESET) begin
            wel_d = 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_IDLE;
            idx_q <= 3'h0;
            opcode_q <= 8'h00;
            addr_q <= 24'h000000;
            wr_ptr_q <= 8'h00;
            mask_q <= '0;
            has_data_q <= 1'b0;
            rst_en_q <= 1'b0;
            wel_q <= 1'b0;
            wip_q <= 1'b0;
            timer_q <= 24'h000000;
            walk_q <= 9'h100;
            page_q <= 16'h0000;
            sec_q <= 1'b0;
            end_pend_q <= 1'b0;
            we_q <= 1'b0;
            soft_q <= 1'b0;
            ign_q <= 1'b0;
            paddr_q <= 24'h000000;
            pdata_q <= 8'h00;
        end else if (i_clk_en) begin
            state_q <= state_d;
            idx_q <= idx_d;
            opcode_q <= opcode_d;
            addr_q <= addr_d;
            wr_ptr_q <= wr_ptr_d;
            mask_q <= mask_d;
            has_data_q <= has_data_d;
            rst_en_q <= rst_en_d;
            wel_q <= wel_d;
            wip_q <= wip_d;
            timer_q <= timer_d;
            walk_q <= walk_d;
            page_q <= page_d;
            sec_q <= sec_d;
            end_pend_q <= end_pend_d;
            we_q <= we_d;
            soft_q <= soft_d;
            ign_q <= ign_d;
            paddr_q <= paddr_d;
            pdata_q <= pdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_write_enable_latch = wel_q;
    assign o_write_in_progress = wip_q;
    assign o_reset_busy = (state_q == ST_RESET);
    assign o_soft_reset = soft_q;
    assign o_cmd_ignored = ign_q;
    assign o_prog_we = we_q;
    assign o_prog_addr = paddr_q;
    assign o_prog_data = pdata_q;
    assign o_prog_security = sec_q;
endmodule : flash_prog_core

// >>> shared/flash_prog_defs.svh
`ifndef FLASH_PROG_DEFS_SVH
`define FLASH_PROG_DEFS_SVH

// ----------------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------------
`define OP_PAGE_PROG 8'h02
`define OP_QUAD_PROG 8'h32
`define OP_SEC_PROG 8'h42
`define OP_RESET_ENABLE 8'h66
`define OP_RESET 8'h99

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define IDX_LAST_ADDR 3'h3
`define IDX_DATA 3'h4
`define BITS_PER_BYTE 4'h8
`define SEC_ADDR_HI 8'h00
`define SEC_ADDR_MID 4'h0
`define SEC_SEL_FIRST 4'h1
`define SEC_SEL_LAST 4'h3
`define PAGE_BYTES 256

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLOCK_PERIOD_NS 8
`define SOFT_RESET_TIME_US 30
`define SOFT_RESET_CYCLES (((`SOFT_RESET_TIME_US * 1000) + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define PAGE_PROGRAM_TIME_US 1000
`define PAGE_PROGRAM_CYCLES (((`PAGE_PROGRAM_TIME_US * 1000) + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// >>> shared/flash_prog_pkg.sv
package flash_prog_pkg;

    // Command engine states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PROG,
        ST_RESET
    } engine_state_t;

    typedef logic [7:0] byte_t;

endpackage : flash_prog_pkg

// >>> shared/spi_rx_if.sv
`timescale 1ns/100ps

// Bytes and frame state handed from the serial-clock side to the core
interface spi_rx_if;
    logic [7:0] rx_byte;
    logic byte_toggle;
    logic partial;

    modport link (
        output rx_byte,
        output byte_toggle,
        output partial
    );

    modport core (
        input rx_byte,
        input byte_toggle,
        input partial
    );
endinterface : spi_rx_if

// >>> rtl/byte_fifo.sv
`timescale 1ns/100ps

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad
            $error("byte_fifo needs DEPTH >= 2 and WIDTH >= 1");
        end
    endgenerate

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] rd_q, rd_d, wr_q, wr_d;
    logic [PW:0] count_q, count_d;
    logic push, pop;

    // ------------------------------------------------------------------
    // Pointers and fill level
    // ------------------------------------------------------------------
    assign o_in_ready = (count_q != (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign o_out_valid = (count_q != '0);
    assign o_out_data = mem_q[rd_q];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    // Next pointer values, wrapping at the depth
    always_comb begin
        rd_d = rd_q;
        wr_d = wr_q;
        count_d = count_q;
        if (push) begin
            wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_q + 1'b1);
        end
        if (pop) begin
            rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_q + 1'b1);
        end
        if (push && !pop) begin
            count_d = (PW+1)'(count_q + 1'b1);
        end else if (pop && !push) begin
            count_d = (PW+1)'(count_q - 1'b1);
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_q <= '0;
            wr_q <= '0;
            count_q <= '0;
        end else if (i_clk_en) begin
            rd_q <= rd_d;
            wr_q <= wr_d;
            count_q <= count_d;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge i_clock) begin
        if (i_clk_en && push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end
endmodule : byte_fifo

// >>> rtl/spi_link_rx.sv
`timescale 1ns/100ps
`include "flash_prog_defs.svh"

module spi_link_rx
    import flash_prog_pkg::*;
(
    input wire logic i_rst_b,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic [3:0] i_io,
    input wire logic i_quad_enable,
    spi_rx_if.link link
);
    logic frame_rst_b;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic [2:0] idx_q, idx_d;
    byte_t opcode_q, opcode_d, shift_q, shift_d;
    byte_t byte_q, byte_d;
    logic toggle_q, toggle_d, partial_q, partial_d;
    logic qe_sync1_q, qe_sync2_q;
    logic quad, done;

    // ------------------------------------------------------------------
    // Frame-local shifting, cleared while chip select is high
    // ------------------------------------------------------------------
    assign frame_rst_b = i_rst_b & ~i_cs_n;
    assign quad = (idx_q == `IDX_DATA) && (opcode_q == `OP_QUAD_PROG) && qe_sync2_q;

    // Rising-edge sampling, MSB first, one or four lanes
    always_comb begin
        shift_d = quad ? {shift_q[3:0], i_io} : {shift_q[6:0], i_io[0]};
        bit_cnt_d = bit_cnt_q + (quad ? 4'h4 : 4'h1);
        done = (bit_cnt_d == `BITS_PER_BYTE);
        idx_d = idx_q;
        opcode_d = opcode_q;
        byte_d = byte_q;
        toggle_d = toggle_q;
        if (done) begin
            bit_cnt_d = 4'h0;
            byte_d = shift_d;
            toggle_d = ~toggle_q;
            if (idx_q != `IDX_DATA) begin
                idx_d = 3'(idx_q + 3'h1);
            end
            if (idx_q == 3'h0) begin
                opcode_d = shift_d;
            end
        end
        partial_d = (bit_cnt_d != 4'h0);
    end

    always_ff @(posedge i_sck or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            bit_cnt_q <= 4'h0;
            idx_q <= 3'h0;
            opcode_q <= 8'h00;
            shift_q <= 8'h00;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            idx_q <= idx_d;
            opcode_q <= opcode_d;
            shift_q <= shift_d;
        end
    end

    // Values that outlive the frame for the core to pick up
    always_ff @(posedge i_sck or negedge i_rst_b) begin
        if (!i_rst_b) begin
            byte_q <= 8'h00;
            toggle_q <= 1'b0;
            partial_q <= 1'b0;
            qe_sync1_q <= 1'b0;
            qe_sync2_q <= 1'b0;
        end else begin
            if (!i_cs_n) begin
                byte_q <= byte_d;
                toggle_q <= toggle_d;
                partial_q <= partial_d;
            end
            qe_sync1_q <= i_quad_enable;
            qe_sync2_q <= qe_sync1_q;
        end
    end

    assign link.rx_byte = byte_q;
    assign link.byte_toggle = toggle_q;
    assign link.partial = partial_q;
endmodule : spi_link_rx

// >>> verif/flash_prog_checker.sv
`timescale 1ns/100ps
module flash_prog_checker #(
    parameter int PROG_CYCLES = 300
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_write_enable_set,
    input wire logic [2:0] i_security_lock_bits,
    input wire logic o_write_enable_latch,
    input wire logic o_write_in_progress,
    input wire logic o_reset_busy,
    input wire logic o_soft_reset,
    input wire logic o_prog_we,
    input wire logic [23:0] o_prog_addr,
    input wire logic o_prog_security,
    input wire logic o_rx_stall
);
    int wip_q, wip_d, rb_q, rb_d;
    // Span counters
    always_comb begin
        wip_d = o_write_in_progress ? wip_q + 1 : 0;
        rb_d = o_reset_busy ? rb_q + 1 : 0;
    end
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wip_q <= 0;
            rb_q <= 0;
        end else begin
            wip_q <= wip_d;
            rb_q <= rb_d;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    sequence s_reset_start;
        o_soft_reset ##1 o_reset_busy;
    endsequence
    AST_WIP_WEL: assert property ($rose(o_write_in_progress) && !$past(i_write_enable_set)
        |-> !o_write_enable_latch) else $error("latch set at program start");
    AST_WIP_LEN: assert property ($fell(o_write_in_progress) && !(o_reset_busy || o_soft_reset)
        |-> wip_q == PROG_CYCLES) else $error("program time wrong");
    AST_WE_WIP: assert property (o_prog_we |-> o_write_in_progress) else $error("write outside cycle");
    AST_SR_BUSY: assert property (o_soft_reset |-> s_reset_start) else $error("no reset wait");
    AST_SR_CLR: assert property (o_soft_reset |=> !o_write_in_progress && !o_write_enable_latch)
        else $error("state kept over reset");
    AST_BUSY_LEN: assert property ($fell(o_reset_busy) |-> rb_q == 3750) else $error("reset wait length");
    AST_NO_WE: assert property (o_reset_busy && !o_soft_reset |-> !o_prog_we) else $error("write in reset");
    AST_SEC_ADDR: assert property (o_prog_we && o_prog_security |-> o_prog_addr[23:16] == 8'h00
        && o_prog_addr[11:8] == 4'h0 && o_prog_addr[15:12] inside {[4'h1:4'h3]}) else $error("bad sec addr");
    AST_SEC_LOCK: assert property (o_prog_we && o_prog_security
        |-> !i_security_lock_bits[o_prog_addr[13:12] - 2'h1]) else $error("locked register written");
    AST_NO_STALL: assert property (!o_rx_stall) else $error("byte buffer overrun");
endmodule : flash_prog_checker

bind flash_prog_core flash_prog_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (.i_clock, .i_rst_b,
    .i_write_enable_set, .i_security_lock_bits, .o_write_enable_latch, .o_write_in_progress,
    .o_reset_busy, .o_soft_reset, .o_prog_we, .o_prog_addr, .o_prog_security, .o_rx_stall);

// >>> verif/spi_host.sv
`timescale 1ns/100ps
module spi_host
    import flash_prog_pkg::*;
(
    output logic o_sck,
    output logic o_cs_n,
    output logic [3:0] o_io
);
    int left;
    // Idle lines
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_io = 4'h0;
    end
    // One clock edge, data set while clock low
    task automatic edge_out(input logic [3:0] v);
        if (left > 0) begin
            o_sck = 1'b0;
            o_io = v;
            #15 o_sck = 1'b1;
            #15 left--;
        end
    endtask : edge_out
    // Frame: opcode, address on one lane, data quad or single
    task automatic send(input byte_t b[$], input int cut, input bit quad, input bit m3);
        left = (quad ? 32 + 2 * (b.size() - 4) : 8 * b.size()) - cut;
        o_sck = m3;
        #7 o_cs_n = 1'b0;
        #15;
        foreach (b[i]) begin
            if (quad && i > 3) begin
                edge_out(b[i][7:4]);
                edge_out(b[i][3:0]);
            end else begin
                for (int k = 7; k >= 0; k--) edge_out({3'h0, b[i][k]});
            end
        end
        o_sck = m3;
        #15 o_cs_n = 1'b1;
        o_io = ~o_io;
        #120;
    endtask : send
endmodule : spi_host

// >>> verif/tb_top.sv
`timescale 1ns/100ps
module tb_top
    import flash_prog_pkg::*;
;
    logic i_clock, i_rst_b, i_write_enable_set, i_quad_enable, i_sck, i_cs_n;
    logic o_write_enable_latch, o_write_in_progress, o_reset_busy, o_soft_reset, o_cmd_ignored;
    logic o_prog_we, o_prog_security, last_sec;
    logic [4:0] i_block_protect_bits;
    logic [2:0] i_security_lock_bits;
    logic [3:0] i_io;
    logic [23:0] o_prog_addr;
    logic [7:0] o_prog_data;
    byte_t mem [int];
    byte_t q [$];
    int n_fail, checks_done, n_wr, n_ign, n_sr;

    spi_host host (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_io(i_io));
    flash_prog_core #(.PROG_CYCLES(300)) uut (.i_clock, .i_rst_b, .i_clk_en(1'b1), .i_sck, .i_cs_n, .i_io,
        .i_quad_enable, .i_block_protect_bits, .i_security_lock_bits, .i_write_enable_set,
        .o_write_enable_latch, .o_write_in_progress, .o_reset_busy, .o_soft_reset, .o_cmd_ignored,
        .o_rx_stall(), .o_prog_we, .o_prog_addr, .o_prog_data, .o_prog_security);

    // --------
    // Tasks
    // --------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic frame(input byte_t b[$], input int cut = 0, input bit quad = 0, input bit m3 = 0);
        {n_wr, n_ign, n_sr} = 0;
        mem.delete();
        host.send(b, cut, quad, m3);
        repeat (20) @(posedge i_clock);
        #1;
    endtask : frame
    task automatic arm;
        @(posedge i_clock) #1 i_write_enable_set = 1'b1;
        @(posedge i_clock);
        #1 i_write_enable_set = 1'b0;
    endtask : arm
    task automatic accepted(input byte_t b[$], input int nexp, input bit quad = 0, input bit m3 = 0);
        arm();
        frame(b, 0, quad, m3);
        check(o_write_in_progress, 1'b1);
        check(o_write_enable_latch, 1'b0);
        repeat (400) if (o_write_in_progress === 1'b1) @(posedge i_clock);
        #1 check(o_write_in_progress, 1'b0);
        check(n_wr, nexp);
    endtask : accepted
    task automatic refused(input byte_t b[$], input int cut = 0, input bit quad = 0, input bit we = 1,
        input int nign = 1);
        if (we) arm();
        frame(b, cut, quad);
        check(n_ign, nign);
        check(o_write_in_progress, 1'b0);
    endtask : refused
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // --------
    // Clock, monitor, watchdog
    // --------
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        if (o_prog_we === 1'b1) begin
            mem[o_prog_addr] = o_prog_data;
            last_sec = o_prog_security;
            n_wr++;
        end
        n_ign += (o_cmd_ignored === 1'b1);
        n_sr += (o_soft_reset === 1'b1);
    end
    initial begin
        #600000 n_fail++;
        complete_run();
    end

    // Test sequence
    initial begin
        {i_rst_b, i_write_enable_set, i_quad_enable} = 3'h0;
        i_block_protect_bits = 5'h01;
        i_security_lock_bits = 3'h2;
        repeat (3) @(posedge i_clock);
        #1 i_rst_b = 1'b1;
        repeat (3) @(posedge i_clock);
        accepted('{8'h02, 8'h12, 8'h34, 8'hFE, 8'hA1, 8'hB2, 8'hC3}, 3);
        check(mem[24'h123400], 8'hC3);
        check(mem[24'h1234FF], 8'hB2);
        $display("test page done");
        i_quad_enable = 1'b1;
        accepted('{8'h32, 8'h00, 8'h00, 8'h10, 8'h5A, 8'hE7}, 2, 1, 1);
        check(mem[24'h000011], 8'hE7);
        i_quad_enable = 1'b0;
        refused('{8'h32, 8'h00, 8'h00, 8'h10, 8'h5A}, 0, 0);
        $display("test quad done");
        refused('{8'h02, 8'h00, 8'h01, 8'h00, 8'h11, 8'h22}, 1);
        refused('{8'h02, 8'hFF, 8'h00, 8'h00, 8'h77});
        refused('{8'h42, 8'h00, 8'h20, 8'h05, 8'h99});
        accepted('{8'h42, 8'h00, 8'h10, 8'h05, 8'h99}, 1);
        check(last_sec, 1'b1);
        check(mem[24'h001005], 8'h99);
        $display("test refusals done");
        q = '{8'h02, 8'h00, 8'h00, 8'h00};
        for (int n = 0; n < 258; n++) q.push_back(n[8:1]);
        accepted(q, 256);
        check(mem[24'h000000], 8'h80);
        check(mem[24'h000002], 8'h01);
        $display("test overflow done");
        check(o_write_in_progress, 1'b0);
        frame('{8'h66});
        frame('{8'h00});
        frame('{8'h99});
        check(n_sr, 0);
        arm();
        frame('{8'h02, 8'h00, 8'h03, 8'h00, 8'h44});
        frame('{8'h66});
        frame('{8'h99});
        check(n_sr, 1);
        check({o_write_in_progress, o_write_enable_latch, o_reset_busy}, 3'h1);
        refused('{8'h02, 8'h00, 8'h03, 8'h00, 8'h44}, 0, 0, 1, 0);
        repeat (4000) if (o_reset_busy === 1'b1) @(posedge i_clock);
        #1 refused('{8'h02, 8'h00, 8'h05, 8'h00, 8'h11}, 0, 0, 0);
        $display("test reset done");
        complete_run();
    end
endmodule : tb_top
